/* core/lspc_pkg.sv */
// Function
// - Wake-up is reset, wake or any input
// - Fail from supply loss or watchdog expiry
// - Fault ORs channel flags, undervoltage, qualified overvoltage
// - Mode chosen from wake-up, fail, fault
// - Sleep: outputs off, settings read zero
// - Fault: faulted outputs off, retry stays active
// - Normal-mode flag high only in Normal
// - Normal drive: direct path or PWM path
// - Fault release term per channel
// - PWM drives output when enabled and on
// - PWM clock from pin zero or internal
// - Select bit high picks internal clock
// - Duty code n gives (n+1)/128, all-ones full
// - Delay code shifts PWM by 16 ticks per step
// - Pin-zero clock monitored, failure stops PWM
// - Calibration pulse length over 128 sets period
// - Out-of-window calibration pulse is ignored
// - Watchdog armed on rising wake inputs
// - Fail-safe: outputs follow inputs, settings default
// - Exit word with good supply leaves fail-safe
// - Grounded fail-safe pin releases watchdog fail-safe
// - Normal to fail-safe clears latched faults
// - SPI sample on fall, shift on rise
package lspc_pkg;
   localparam int          NCH          = 4;
   localparam int          DUTY_W       = 7;
   localparam int          DLY_W        = 3;
   localparam int          SPI_W        = 16;
   localparam int          CW           = 24;
   localparam int          KA_BIT       = 15;
   localparam int          EXIT_BIT     = 14;
   localparam logic [14:0] CAL_CMD      = 15'h2A5A;
   localparam logic [6:0]  PWM_FULL     = 7'h7F;
   localparam int          DLY_SH       = 4;
   localparam int          CAL_DIV_SH   = 7;
   localparam logic [31:0] KEEPALIVE_TIMEOUT_CYC_DEF = 32'h001E_8480;
   localparam logic [23:0] CAL_MIN_DEF  = 24'h00_0400;
   localparam logic [23:0] CAL_MAX_DEF  = 24'h80_0000;
   localparam logic [23:0] MON_LO_DEF   = 24'h00_0800;
   localparam logic [23:0] MON_HI_DEF   = 24'h00_8000;
   localparam logic [23:0] INT_PER_DEF  = 24'h00_1000;

   typedef enum logic [1:0] {
      ST_SLEEP  = 2'h0,
      ST_NORMAL = 2'h1,
      ST_FAULT  = 2'h3,
      ST_FSAFE  = 2'h2
   } lspc_mode_t;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'h0,
      CAL_ARM  = 2'h1,
      CAL_MEAS = 2'h3
   } lspc_cal_t;

   typedef struct packed {
      logic                           pwm_en;
      logic                           clock_sel;
      logic                           supply_high_protect_off;
      logic                           vdd_fail_en;
      logic [NCH-1:0]                 on;
      logic [NCH-1:0]                 dir_dis;
      logic [NCH-1:0][DUTY_W-1:0]     duty;
      logic [NCH-1:0][DLY_W-1:0]      dly;
   } lspc_cfg_t;

   typedef struct packed {
      logic [NCH-1:0] overcurrent_flags;
      logic [NCH-1:0] overtemp_flags;
      logic [NCH-1:0] severe_short_flags;
      logic           undervoltage_flag;
      logic           supply_high_flag;
   } lspc_flt_t;
endpackage

/* core/lspc_core.sv */
module lspc_core import lspc_pkg::*; #(
   parameter logic [31:0] KEEPALIVE_TIMEOUT_CYC = KEEPALIVE_TIMEOUT_CYC_DEF,
   parameter logic [23:0] CAL_MIN  = CAL_MIN_DEF,
   parameter logic [23:0] CAL_MAX  = CAL_MAX_DEF,
   parameter logic [23:0] MON_LO   = MON_LO_DEF,
   parameter logic [23:0] MON_HI   = MON_HI_DEF,
   parameter logic [23:0] INT_PER  = INT_PER_DEF
) (
   input  wire logic       CLK_IN,
   input  wire logic       RST_IN,
   input  wire logic       WAKE_IN,
   input  wire logic       RESET_PIN_IN,
   input  wire logic [3:0] INPUT_PINS_IN,
   input  wire logic       FAILSAFE_INPUT_PIN_IN,
   input  wire logic       VDD_FAIL_IN,
   input  wire lspc_cfg_t  CFG_IN,
   input  wire lspc_flt_t  FLAGS_IN,
   input  wire logic       SCLK_IN,
   input  wire logic       CS_N_IN,
   input  wire logic       SI_IN,
   output logic [3:0]      HIGH_SIDE_OUTPUTS_OUT,
   output logic [3:0]      FAULT_RELEASE_OUT,
   output logic            NORMAL_MODE_FLAG_OUT,
   output logic            CLOCK_FAIL_OUT,
   output logic            KEEPALIVE_TIMEOUT_OUT,
   output logic            CLEAR_LATCHED_OUT,
   output lspc_mode_t      MODE_OUT,
   output logic            SO_OUT,
   output logic            SO_OE_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   logic             input_zero_pin;
   lspc_cfg_t        cfg_e;
   lspc_mode_t       mode_q, mode_d;
   logic             fail_q, fail_d;
   logic             wake, fault, word_ev, cs_rise, cs_fall, sclk_fall;
   logic [3:0]       flt_ch, wave, nd;
   assign input_zero_pin = INPUT_PINS_IN[0];

   ////////////////////////////////////////////////////////////////////////
   // SPI shifter, oversampled by the system clock
   logic              sclk_q, cs_q, oe_q, oe_d, ka_q, ka_d;
   logic [SPI_W-1:0]  sh_q, sh_d, so_q, so_d;
   lspc_cal_t         cal_st_q, cal_st_d;

   assign sclk_fall = sclk_q & ~SCLK_IN;
   assign cs_rise   = ~cs_q & CS_N_IN;
   assign cs_fall   = cs_q & ~CS_N_IN;
   // The closing edge of a calibration pulse carries no word
   assign word_ev   = cs_rise & (cal_st_q != CAL_MEAS);

   always_comb begin
      sh_d = sh_q;
      so_d = so_q;
      ka_d = ka_q;
      oe_d = ~CS_N_IN;
      if (!CS_N_IN && sclk_fall) begin
         sh_d = {sh_q[SPI_W-2:0], SI_IN};
      end
      if (cs_fall) begin
         so_d = {NORMAL_MODE_FLAG_OUT, CLOCK_FAIL_OUT,
                 KEEPALIVE_TIMEOUT_OUT, fail_q, mode_q,
                 HIGH_SIDE_OUTPUTS_OUT, FAULT_RELEASE_OUT, 2'h0};
      end else if (!CS_N_IN && !sclk_q && SCLK_IN) begin
         so_d = {so_q[SPI_W-2:0], 1'b0};
      end
      if (word_ev) begin
         ka_d = sh_q[KA_BIT];
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
         sh_q   <= '0;
         so_q   <= '0;
         ka_q   <= 1'b0;
         oe_q   <= 1'b0;
      end else begin
         sclk_q <= SCLK_IN;
         cs_q   <= CS_N_IN;
         sh_q   <= sh_d;
         so_q   <= so_d;
         ka_q   <= ka_d;
         oe_q   <= oe_d;
      end
   end
   assign SO_OUT    = so_q[SPI_W-1];
   assign SO_OE_OUT = oe_q;

   ////////////////////////////////////////////////////////////////////////
   // Internal clock, calibration, pin-zero monitor and PWM counter
   logic [CW-1:0] div_q, div_d, per_q, per_d, cal_q, cal_d, mon_q, mon_d;
   logic          in0_q, cfail_q, cfail_d, int_tick, ext_rise, tick;
   logic [6:0]    pcnt_q, pcnt_d;

   assign int_tick = (div_q >= per_q - 24'h1);
   assign ext_rise = input_zero_pin & ~in0_q;
   // Internal source when selected, else pin zero only while healthy
   assign tick = cfg_e.clock_sel ? int_tick
                                 : (ext_rise & ~cfail_q);

   always_comb begin
      div_d    = int_tick ? '0 : div_q + 24'h1;
      per_d    = per_q;
      cal_d    = cal_q;
      cal_st_d = cal_st_q;
      pcnt_d   = tick ? pcnt_q + 7'h1 : pcnt_q;
      mon_d    = ext_rise ? '0 : ((&mon_q) ? mon_q : mon_q + 24'h1);
      cfail_d  = ext_rise ? (mon_q < MON_LO || mon_q > MON_HI)
                          : (cfail_q | (mon_q > MON_HI));
      unique case (cal_st_q)
         CAL_IDLE: begin
            if (word_ev && sh_q[14:0] == CAL_CMD) begin
               cal_st_d = CAL_ARM;
            end
         end
         CAL_ARM: begin
            if (cs_fall) begin
               cal_d    = '0;
               cal_st_d = CAL_MEAS;
            end
         end
         CAL_MEAS: begin
            cal_d = (&cal_q) ? cal_q : cal_q + 24'h1;
            if (cs_rise) begin
               cal_st_d = CAL_IDLE;
               // Outside the window the old period simply stays
               if (cal_q >= CAL_MIN && cal_q <= CAL_MAX) begin
                  per_d = cal_q >> CAL_DIV_SH;
               end
            end
         end
         default: cal_st_d = CAL_IDLE;
      endcase
      if (!wake) begin
         cal_st_d = CAL_IDLE;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         div_q    <= '0;
         per_q    <= INT_PER;
         cal_q    <= '0;
         cal_st_q <= CAL_IDLE;
         mon_q    <= '0;
         cfail_q  <= 1'b0;
         in0_q    <= 1'b0;
         pcnt_q   <= '0;
      end else begin
         div_q    <= div_d;
         per_q    <= per_d;
         cal_q    <= cal_d;
         cal_st_q <= cal_st_d;
         mon_q    <= mon_d;
         cfail_q  <= cfail_d;
         in0_q    <= input_zero_pin;
         pcnt_q   <= pcnt_d;
      end
   end
   assign CLOCK_FAIL_OUT = cfail_q;

   ////////////////////////////////////////////////////////////////////////
   // Per-channel waveform and Normal-mode drive
   always_comb begin
      logic [6:0] ph;
      ph = '0;
      for (int i = 0; i < NCH; i++) begin
         ph = pcnt_q - {cfg_e.dly[i], 4'h0};
         wave[i] = (cfg_e.duty[i] == PWM_FULL)
                 | (ph <= cfg_e.duty[i]);
         if (cfg_e.pwm_en) begin
            // A failed pin-zero clock leaves the on bit in charge
            nd[i] = cfg_e.on[i] & ((cfail_q & ~cfg_e.clock_sel)
                                   | wave[i]);
         end else begin
            nd[i] = (INPUT_PINS_IN[i] & ~cfg_e.dir_dis[i])
                  | cfg_e.on[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog, fail latch and operating mode
   logic [5:0]  pv_q, cur;
   logic        wd_arm_q, wd_arm_d, keepalive_timeout_q, keepalive_timeout_d, kick, fexit, fsi_open;
   logic [31:0] wd_q, wd_d;
   logic [3:0]  hs_q, hs_d, rel_q, rel_d;
   logic        nm_q, nm_d, clr_q, clr_d;

   assign cur      = {WAKE_IN, RESET_PIN_IN, INPUT_PINS_IN};
   assign wake     = |cur;
   assign fsi_open = FAILSAFE_INPUT_PIN_IN;
   assign kick     = word_ev & (sh_q[KA_BIT] != ka_q);
   assign fexit    = word_ev & sh_q[EXIT_BIT] & fail_q & ~VDD_FAIL_IN;
   assign cfg_e    = (wake && !fail_q && mode_q != ST_SLEEP)
                   ? CFG_IN : '0;

   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         flt_ch[i] = FLAGS_IN.overcurrent_flags[i]
                   | FLAGS_IN.overtemp_flags[i]
                   | FLAGS_IN.severe_short_flags[i]
                   | FLAGS_IN.undervoltage_flag
                   | (FLAGS_IN.supply_high_flag
                      & ~cfg_e.supply_high_protect_off);
      end
   end
   assign fault = |flt_ch;

   always_comb begin
      wd_arm_d = fsi_open & (wd_arm_q | (|(cur & ~pv_q)));
      wd_d     = (!wd_arm_q || !fsi_open || kick || keepalive_timeout_q)
               ? '0 : wd_q + 32'h1;
      // New expiry beats an exit-word clear landing in the same cycle
      keepalive_timeout_d   = (wd_arm_q && fsi_open && wd_q == KEEPALIVE_TIMEOUT_CYC - 32'h1)
               | (keepalive_timeout_q & ~fexit & fsi_open);
      // Grounded fail-safe pin releases a watchdog-caused fail
      fail_d   = wake & ((VDD_FAIL_IN & CFG_IN.vdd_fail_en)
                 | (keepalive_timeout_q & ~fexit & fsi_open)
                 | (fail_q & ~fexit & fsi_open));
      if (!wake) begin
         mode_d = ST_SLEEP;
      end else if (fault) begin
         mode_d = ST_FAULT;
      end else if (fail_d) begin
         mode_d = ST_FSAFE;
      end else begin
         mode_d = ST_NORMAL;
      end
      if (mode_d == ST_SLEEP) begin
         hs_d = '0;
      end else if (fail_d) begin
         hs_d = INPUT_PINS_IN & ~flt_ch;
      end else begin
         hs_d = nd & ~flt_ch;
      end
      rel_d = wake ? ((INPUT_PINS_IN & ~cfg_e.dir_dis
                       & {NCH{~cfg_e.pwm_en}}) | cfg_e.on)
                   : '0;
      nm_d  = (mode_d == ST_NORMAL);
      clr_d = (mode_q == ST_NORMAL && mode_d == ST_FSAFE)
            | (mode_q == ST_FSAFE && mode_d == ST_NORMAL);
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         pv_q     <= '0;
         wd_arm_q <= 1'b0;
         wd_q     <= '0;
         keepalive_timeout_q   <= 1'b0;
         fail_q   <= 1'b0;
         mode_q   <= ST_SLEEP;
         hs_q     <= '0;
         rel_q    <= '0;
         nm_q     <= 1'b0;
         clr_q    <= 1'b0;
      end else begin
         pv_q     <= cur;
         wd_arm_q <= wd_arm_d;
         wd_q     <= wd_d;
         keepalive_timeout_q   <= keepalive_timeout_d;
         fail_q   <= fail_d;
         mode_q   <= mode_d;
         hs_q     <= hs_d;
         rel_q    <= rel_d;
         nm_q     <= nm_d;
         clr_q    <= clr_d;
      end
   end
   assign HIGH_SIDE_OUTPUTS_OUT = hs_q;
   assign FAULT_RELEASE_OUT     = rel_q;
   assign NORMAL_MODE_FLAG_OUT  = nm_q;
   assign KEEPALIVE_TIMEOUT_OUT = keepalive_timeout_q;
   assign CLEAR_LATCHED_OUT     = clr_q;
   assign MODE_OUT              = mode_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_n2f;
      mode_q == ST_NORMAL ##1 mode_q == ST_FSAFE;
   endsequence
   sequence s_cal_ok;
      cal_st_q == CAL_MEAS && cs_rise && cal_q >= CAL_MIN
         && cal_q <= CAL_MAX;
   endsequence

   AST_SLEEP_OFF: assert property (
      mode_q == ST_SLEEP |-> hs_q == 4'h0)
      else $error("output on in sleep");
   AST_NM_FLAG: assert property (
      nm_q == (mode_q == ST_NORMAL))
      else $error("normal flag disagrees with mode");
   AST_MODE_SLEEP: assert property (
      !wake |=> mode_q == ST_SLEEP && !fail_q)
      else $error("no sleep without wake-up");
   AST_FAULT_OFF: assert property (
      wake && flt_ch[0] |=> mode_q == ST_FAULT && !hs_q[0])
      else $error("faulted output left on");
   AST_FS_FOLLOW: assert property (
      wake && fail_d && !fault |=> hs_q == $past(INPUT_PINS_IN)
         && !nm_q)
      else $error("fail-safe output not following input");
   AST_CLR_N2F: assert property (
      s_n2f |-> clr_q)
      else $error("no clear on entry to fail-safe");
   AST_FULL_ON: assert property (
      cfg_e.duty[1] == PWM_FULL |-> wave[1])
      else $error("full duty code not fully on");
   AST_PWM_OFFBIT: assert property (
      wake && !fail_d && cfg_e.pwm_en && !cfg_e.on[2]
         |=> !hs_q[2])
      else $error("pwm output on with on bit clear");
   AST_WD_OFF: assert property (
      !fsi_open |=> !wd_arm_q && wd_q == 32'h0)
      else $error("watchdog running with pin grounded");
   AST_CAL_SET: assert property (
      s_cal_ok |=> per_q == ($past(cal_q) >> CAL_DIV_SH))
      else $error("calibrated period wrong");
   AST_CAL_BAD: assert property (
      cal_st_q == CAL_MEAS && cs_rise && cal_q < CAL_MIN
         |=> $stable(per_q))
      else $error("short calibration pulse accepted");
   AST_CFAIL: assert property (
      cfail_q && !cfg_e.clock_sel |-> !tick)
      else $error("pwm ticking on failed clock");
endmodule

/* tb/lspc_host.sv */
module lspc_host (
   input  wire logic clk_in,
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      si_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ka_q = 1'b0;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out   = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Clock low for three cycles and high for two; the core accepts phases of one cycle
   task automatic send_word(input logic [14:0] body);
      logic [15:0] w;
      ka_q = ~ka_q; // Every word kicks the watchdog
      w = {ka_q, body}; // Keep-alive bit on top of an exit, calibrate or plain body
      @(negedge clk_in);
      cs_n_out = ~cs_n_out;
      for (int i = 15; i >= 0; i--) begin
         @(negedge clk_in);
         si_out = w[i];
         repeat (2) @(negedge clk_in);
         sclk_out = ~sclk_out;
         repeat (2) @(negedge clk_in);
         sclk_out = ~sclk_out;
      end
      repeat (2) @(negedge clk_in);
      cs_n_out = ~cs_n_out;
      // Released line must not keep showing the last bit
      si_out = ~si_out;
      repeat (2) @(negedge clk_in);
   endtask
   // Low pulse on chip select after the calibrate word
   task automatic cal_pulse(input int len);
      @(negedge clk_in);
      cs_n_out = ~cs_n_out;
      repeat (len) @(negedge clk_in);
      cs_n_out = ~cs_n_out;
      repeat (4) @(negedge clk_in);
   endtask
endmodule

/* tb/test_lamp_switch_mode_pwm_control.sv */
module test_lamp_switch_mode_pwm_control
   import lspc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int k; logic [15:0] v;} lspc_note_t;
   logic       clk, rst, wake, rpin, failsafe_input_pin, vdd, ext_on, ext_clk;
   logic [3:0] in_v, pins, hs, rel;
   logic       sclk, cs_n, si, nm, cf, keepalive_timeout, clr, so, so_oe;
   logic [1:0] ph = 2'h0;
   lspc_mode_t mode;
   lspc_cfg_t  cfg;
   lspc_flt_t  flt;
   int         bad_count = 0;
   int         compares = 0;
   int         cyc = 0;
   int         clr_cnt = 0;
   int         seed = 32'h25e9926d;
   logic [15:0] meas;
   logic [6:0] dt [4] = '{7'h00, 7'h05, 7'h7E, 7'h7F};
   lspc_note_t q[$];
   event       smp;
   assign pins = {in_v[3:1], ext_on ? ext_clk : in_v[0]};
   lspc_core #(.KEEPALIVE_TIMEOUT_CYC(32'h0000_00C8), .MON_LO(24'h00_0002),
      .MON_HI(24'h00_0040), .INT_PER(24'h00_0004))
      u_dut (.CLK_IN(clk), .RST_IN(rst),
      .WAKE_IN(wake), .RESET_PIN_IN(rpin), .INPUT_PINS_IN(pins),
      .FAILSAFE_INPUT_PIN_IN(failsafe_input_pin), .VDD_FAIL_IN(vdd), .CFG_IN(cfg),
      .FLAGS_IN(flt), .SCLK_IN(sclk), .CS_N_IN(cs_n), .SI_IN(si),
      .HIGH_SIDE_OUTPUTS_OUT(hs), .FAULT_RELEASE_OUT(rel),
      .NORMAL_MODE_FLAG_OUT(nm), .CLOCK_FAIL_OUT(cf),
      .KEEPALIVE_TIMEOUT_OUT(keepalive_timeout), .CLEAR_LATCHED_OUT(clr),
      .MODE_OUT(mode), .SO_OUT(so), .SO_OE_OUT(so_oe));
   lspc_host u_host (.clk_in(clk), .sclk_out(sclk), .cs_n_out(cs_n),
      .si_out(si));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (clr === 1'b1) clr_cnt++;
      if (cyc == 60000) begin
         bad_count++;
         results();
      end
   end
   // External PWM clock on pin zero, period of eight cycles
   always @(negedge clk) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) ext_clk <= ~ext_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      if (bad_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rep(string s, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic cmp_mode(logic [15:0] e);
      rep("mode", e, {14'h0, mode});
   endtask
   task automatic cmp_vec(string s, logic [15:0] e, logic [3:0] g);
      rep(s, e, {12'h0, g});
   endtask
   task automatic cmp_bit(string s, logic [15:0] e, logic g);
      rep(s, e, {15'h0, g});
   endtask
   task automatic cmp_cnt(logic [15:0] e);
      rep("count", e, meas);
   endtask
   initial begin
      lspc_note_t n;
      forever begin
         @(smp);
         // Several notes can land in one time step
         while (q.size() > 0) begin
            n = q.pop_front();
            case (n.k)
               0: cmp_mode(n.v);
               1: cmp_vec("outputs", n.v, hs);
               2: cmp_vec("release", n.v, rel);
               3: cmp_bit("normal flag", n.v, nm);
               4: cmp_bit("clock fail", n.v, cf);
               5: cmp_bit("timeout", n.v, keepalive_timeout);
               7: cmp_vec("serial out", n.v, {2'h0, so_oe, so});
               default: cmp_cnt(n.v);
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic ex(int k, logic [15:0] v);
      lspc_note_t n;
      n.k = k;
      n.v = v;
      q.push_back(n);
      -> smp;
   endtask
   task automatic tk(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic meas_hi(int ch, int n);
      meas = 16'h0;
      repeat (n) begin
         @(negedge clk);
         meas = meas + {15'h0, hs[ch]};
      end
   endtask
   // Bounded wait for a low then a high level, counting cycles
   task automatic rise(int ch);
      for (int i = 0; i < 1200 && hs[ch] !== 1'b0; i++) tk(1);
      for (int i = 0; i < 1200 && hs[ch] !== 1'b1; i++) begin
         tk(1);
         meas++;
      end
   endtask
   // Length of the high run that starts where rise() stopped
   task automatic hi_run(int ch);
      meas = 16'h0;
      for (int i = 0; i < 1200 && hs[ch] === 1'b1; i++) begin
         tk(1);
         meas++;
      end
   endtask
   task automatic wait_mode(lspc_mode_t m);
      for (int i = 0; i < 400 && mode !== m; i++) tk(1);
      tk(2);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      {rst, wake, rpin, failsafe_input_pin, vdd, ext_on, ext_clk} = 7'h40;
      in_v = 4'h0;
      cfg = '0;
      flt = '0;
      tk(2);
      rst = 1'b0;
      cfg.on = 4'hF;
      tk(3);
      ex(0, 16'(ST_SLEEP));
      ex(1, 16'h0);
      ex(7, 16'h0);
      for (int i = 0; i < 6; i++) begin
         r = $random(seed);
         // Watchdog may arm here but the loop ends long before expiry
         failsafe_input_pin = r[0];
         {rpin, wake, in_v} = 6'h01 << i;
         tk(3);
         ex(0, 16'(ST_NORMAL));
         {rpin, wake, in_v} = 6'h00;
         tk(3);
         ex(0, 16'(ST_SLEEP));
      end
      failsafe_input_pin = 1'b0;
      wake = 1'b1;
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         {cfg.dir_dis, cfg.on, in_v} = r[11:0];
         vdd = r[12]; // Supply loss without its enable is no fail
         tk(3);
         ex(1, 16'((in_v & ~cfg.dir_dis) | cfg.on));
         ex(2, 16'((in_v & ~cfg.dir_dis) | cfg.on));
         ex(3, 16'h1);
      end
      cfg.on = 4'hF;
      in_v = 4'h0;
      for (int i = 0; i < 14; i++) begin
         flt = lspc_flt_t'(14'h1 << i);
         tk(3);
         ex(0, 16'(ST_FAULT));
         // Channel flags stop one output, supply flags stop all
         meas = (i < 2) ? 16'h0 : 16'(4'hF & ~(4'h1 << ((i - 2) % 4)));
         ex(1, meas);
      end
      flt = lspc_flt_t'(14'h1);
      cfg.supply_high_protect_off = 1'b1;
      tk(3);
      ex(0, 16'(ST_NORMAL));
      flt = '0;
      vdd = 1'b1;
      tk(3);
      ex(0, 16'(ST_NORMAL));
      cfg.vdd_fail_en = 1'b1;
      tk(3);
      ex(0, 16'(ST_FSAFE));
      ex(3, 16'h0);
      vdd = 1'b0;
      u_host.send_word(15'h4000);
      tk(3);
      ex(0, 16'(ST_NORMAL));
      cfg.vdd_fail_en = 1'b0;
      failsafe_input_pin = 1'b1;
      rpin = 1'b1;
      for (int i = 0; i < 3; i++) begin
         tk(20);
         u_host.send_word(15'h0000);
      end
      ex(0, 16'(ST_NORMAL));
      clr_cnt = 0;
      wait_mode(ST_FSAFE);
      ex(5, 16'h1);
      meas = 16'(clr_cnt);
      ex(6, 16'h1);
      r = $random(seed);
      in_v = r[3:0];
      cfg.on = ~r[3:0];
      tk(3);
      ex(1, 16'(in_v));
      clr_cnt = 0;
      u_host.send_word(15'h4000);
      tk(3);
      ex(0, 16'(ST_NORMAL));
      meas = 16'(clr_cnt);
      ex(6, 16'h1);
      wait_mode(ST_FSAFE);
      ex(0, 16'(ST_FSAFE));
      failsafe_input_pin = 1'b0;
      tk(3);
      ex(0, 16'(ST_NORMAL));
      rpin = 1'b0;
      in_v = 4'hE;
      cfg = '0;
      {cfg.pwm_en, cfg.clock_sel, cfg.on} = 6'h31;
      tk(3);
      ex(2, 16'h1);
      for (int i = 0; i < 4; i++) begin
         cfg.duty[0] = dt[i];
         tk(512);
         meas_hi(0, 512);
         ex(6, (i == 3) ? 16'h0200 : 16'((dt[i] + 8'h01) * 4));
      end
      ex(1, 16'h1);
      cfg.on = 4'h3;
      cfg.duty[0] = 7'h0A;
      cfg.duty[1] = 7'h0A;
      for (int i = 0; i < 2; i++) begin
         cfg.dly[1] = i ? 3'h7 : 3'h1;
         tk(600);
         rise(0);
         meas = 16'h0;
         rise(1);
         ex(6, i ? 16'h01C0 : 16'h0040);
      end
      cfg.dly = '0;
      cfg.on = 4'h5;
      cfg.duty[0] = 7'h1F;
      u_host.send_word(CAL_CMD);
      fork
         u_host.cal_pulse(1088);
         begin
            tk(4);
            ex(7, 16'h3);
         end
      join
      // A 32-tick high run shows the tick period, 1087 >> 7 = 8
      rise(0);
      hi_run(0);
      ex(6, 16'h0100);
      u_host.send_word(CAL_CMD);
      u_host.cal_pulse(100);
      rise(0);
      hi_run(0);
      ex(6, 16'h0100);
      cfg.clock_sel = 1'b0;
      ext_on = 1'b1;
      tk(1100);
      meas_hi(0, 1024);
      ex(6, 16'h0100);
      ex(4, 16'h0);
      ext_on = 1'b0;
      tk(100);
      ex(4, 16'h1);
      ex(1, 16'h5);
      tk(1);
      results();
   end
endmodule
